// *** sim/rtms_sequencer_properties.sv ***
// Assertions on the test message sequencer ports
`timescale 1ns/1ps
module rtms_sequencer_properties #(
	parameter integer LONG_OFF_CYC = 100
) (
	// Clock, reset, enable
	input wire       i_clk,
	input wire       i_rst_b,
	input wire       i_ce,
	// Settings and stream
	input wire       i_test_enable,
	input wire       i_long_pattern,
	input wire       o_tx_valid,
	input wire [7:0] o_tx_data,
	input wire       i_tx_ready,
	// Status
	input wire       o_active,
	input wire       o_long_silent,
	input wire [7:0] o_seq_bcd
);
	integer sil_cnt;
	// Counts enabled cycles of the silent phase
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			sil_cnt <= 0;
		else if (!o_long_silent)
			sil_cnt <= 0;
		else if (i_ce)
			sil_cnt <= sil_cnt + 1;
	end
	// Next BCD number with wrap
	function [7:0] bcd_inc(input [7:0] v);
		bcd_inc = v == 8'h99 ? 8'h00 : v[3:0] == 4'h9 ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_first_byte;
		o_tx_valid && o_tx_data == 8'h30;
	endsequence
	sequence s_held_byte;
		o_tx_valid && $stable(o_tx_data);
	endsequence
	a_off_idle: assert property (!i_test_enable && i_ce |=> !o_active)
		else $error("active while disabled");
	a_start_byte: assert property ($rose(o_active) |-> ##[0:3] s_first_byte)
		else $error("first byte missing");
	a_byte_stands: assert property (o_tx_valid && !(i_tx_ready && i_ce) |=> s_held_byte)
		else $error("byte dropped");
	a_bcd_digits: assert property (o_seq_bcd[7:4] <= 4'h9 && o_seq_bcd[3:0] <= 4'h9)
		else $error("bad digit");
	a_bcd_step: assert property ($changed(o_seq_bcd) |-> o_seq_bcd == 8'h00
		|| o_seq_bcd == bcd_inc($past(o_seq_bcd)))
		else $error("bad number step");
	a_short_quiet: assert property (!i_long_pattern |-> !o_long_silent)
		else $error("silent in short");
	a_silent_len: assert property ($fell(o_long_silent) |->
		sil_cnt >= LONG_OFF_CYC - 1 && sil_cnt <= LONG_OFF_CYC + 1)
		else $error("silence length");
	// The number output lags one cycle, so its last step lands in the second silent cycle
	a_silent_hold: assert property (o_long_silent && $past(o_long_silent) && $past(o_long_silent, 2) |->
		$stable(o_seq_bcd))
		else $error("message in silence");
endmodule // rtms_sequencer_properties
bind rtms_sequencer rtms_sequencer_properties #(.LONG_OFF_CYC(LONG_OFF_CYC)) u_props (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_test_enable(i_test_enable),
	.i_long_pattern(i_long_pattern), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
	.i_tx_ready(i_tx_ready), .o_active(o_active), .o_long_silent(o_long_silent), .o_seq_bcd(o_seq_bcd));

// *** sim/rtms_sink.sv ***
// Model of the far radio taking the byte stream
`timescale 1ns/1ps
module rtms_sink (
	// Clock and command
	input  wire i_clk,
	input  wire i_stall,
	// Handshake
	output reg  o_ready = 1'b1
);
	integer seed = 51443;
	// Takes bytes as plain data, withholding ready at random when told
	always @(negedge i_clk) begin
		o_ready <= !i_stall || ($random(seed) & 3) == 0;
	end
endmodule // rtms_sink

// *** sim/testbench.sv ***
// Self-checking bench for the test message sequencer
`timescale 1ns/1ps
module testbench;
	reg        i_clk = 1'b0;
	reg        i_rst_b = 1'b0;
	reg        i_ce = 1'b1;
	reg        i_test_enable = 1'b1;
	reg        i_long_pattern = 1'b0;
	reg        stall = 1'b0;
	wire       o_tx_valid;
	wire [7:0] o_tx_data;
	wire       i_tx_ready;
	wire       o_active;
	wire       o_long_silent;
	wire [7:0] o_seq_bcd;
	integer    errors = 0;
	integer    num_checks = 0;
	integer    idx = 0;
	integer    n;
	integer    k;
	integer    len;
	integer    left;
	time       t_last = 0;
	int        exp_q[$];
	always #10 i_clk = ~i_clk;
	rtms_sequencer #(.SHORT_PERIOD_CYC(200), .LONG_ON_CYC(400), .LONG_OFF_CYC(100), .FIFO_DEPTH(8)) dut (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_test_enable(i_test_enable),
		.i_long_pattern(i_long_pattern), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
		.i_tx_ready(i_tx_ready), .o_active(o_active), .o_long_silent(o_long_silent), .o_seq_bcd(o_seq_bcd));
	rtms_sink u_sink (.i_clk(i_clk), .i_stall(stall), .o_ready(i_tx_ready));
	// Compares one value and counts it
	task check(input [15:0] seen, input [15:0] want);
		begin
			num_checks = num_checks + 1;
			if (seen !== want) begin
				errors = errors + 1;
				$display("mismatch at %0t: saw %h want %h", $time, seen, want);
			end
		end
	endtask
	// Prints counts and verdict, then stops
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Takes the oldest note at each message start and checks the framing bytes
	always @(posedge i_clk) begin
		len = i_long_pattern ? 37 : 13;
		if (!i_test_enable)
			idx = 0;
		else if (o_tx_valid && i_tx_ready && i_ce) begin
			if (idx == 0) begin
				n = exp_q.size() ? exp_q.pop_front() : 200;
				if (!i_long_pattern && t_last > 0)
					check(16'(($time - t_last) / 20), 16'h00C8);
				t_last = $time;
			end
			if (idx == 0)
				check(o_tx_data, 16'(n / 10) + 16'h0030);
			if (idx == 1)
				check(o_tx_data, 16'(n % 10) + 16'h0030);
			if (idx == 2)
				check(o_tx_data, 16'h0020);
			if (idx == len - 2)
				check(o_tx_data, 16'h000D);
			if (idx == len - 1)
				check(o_tx_data, 16'h000A);
			idx = idx == len - 1 ? 0 : idx + 1;
		end
	end
	// Cuts a hang short
	initial begin
		#1500000;
		errors = errors + 1;
		tally_and_finish;
	end
	// Main sequence: short pattern from reset, then long pattern after a second reset
	initial begin
		for (k = 0; k <= 100; k++)
			exp_q.push_back(k % 100);
		repeat (20) @(negedge i_clk);
		i_rst_b = 1'b1;
		for (k = 0; k < 30000 && (exp_q.size() || idx); k++)
			@(negedge i_clk);
		check(16'(exp_q.size()), 16'h0000);
		i_test_enable = 1'b0;
		repeat (3) @(negedge i_clk);
		check(o_seq_bcd, 16'h0000);
		check(o_active, 16'h0000);
		$display("short pattern test done");
		for (k = 0; k < 40; k++)
			exp_q.push_back(k);
		i_long_pattern = 1'b1;
		i_test_enable = 1'b1;
		stall = 1'b1;
		i_rst_b = 1'b0;
		repeat (3) @(negedge i_clk);
		i_rst_b = 1'b1;
		repeat (50) @(negedge i_clk);
		i_ce = 1'b0;
		repeat (6) @(negedge i_clk);
		i_ce = 1'b1;
		for (k = 0; k < 3000 && !o_long_silent; k++)
			@(negedge i_clk);
		check(o_long_silent, 16'h0001);
		left = exp_q.size();
		for (k = 0; k < 300 && o_long_silent; k++)
			@(negedge i_clk);
		check(o_long_silent, 16'h0000);
		repeat (60) @(negedge i_clk);
		check(o_active, 16'h0001);
		check(16'(left - exp_q.size()), 16'h0001);
		$display("long pattern test done");
		tally_and_finish;
	end
endmodule // testbench

// *** verilog/rtms_defs.vh ***
// Constants for the radio test message sequencer
`ifndef RTMS_DEFS_VH
`define RTMS_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTMS_CLK_HZ        32'h02FAF080
`define RTMS_SHORT_PERIOD_S 1
`define RTMS_LONG_ON_S     50
`define RTMS_LONG_OFF_S    10

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define RTMS_CHR_ZERO      8'h30
`define RTMS_CHR_SPACE     8'h20
`define RTMS_CHR_CR        8'h0D
`define RTMS_CHR_LF        8'h0A
`define RTMS_DIGIT_MAX     4'h9
`define RTMS_CHR_BODY_BASE 8'h61
`define RTMS_BODY_LETTERS  5'h1A

// ----------------------------------------------------------------
// Message layout: 2 digits, space, body, CR, LF
// ----------------------------------------------------------------
`define RTMS_SHORT_BODY_LEN 6'h08
`define RTMS_LONG_BODY_LEN  6'h20
`define RTMS_FRAME_EXTRA    6'h05
`define RTMS_POS_TENS       6'h00
`define RTMS_POS_UNITS      6'h01
`define RTMS_POS_SPACE      6'h02
`define RTMS_POS_BODY       6'h03
`define RTMS_TAIL_CR        6'h02
`define RTMS_TAIL_LF        6'h01
`define RTMS_FIFO_DEPTH     8

`endif

// *** verilog/rtms_fifo.v ***
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module rtms_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst_b,
	input  wire             i_ce,
	// Fill side
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	// Drain side
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// Handshakes
	assign o_in_ready  = (count != DEPTH[AW:0]);
	assign o_out_valid = (count != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_ce & i_in_valid & o_in_ready;
	assign pop         = i_ce & o_out_valid & i_out_ready;

	// Storage write
	always @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	// Pointers and fill count
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // rtms_fifo

// *** verilog/rtms_sequencer.v ***
// Test message sequencer: builds numbered test lines and paces them
`timescale 1ns/1ps
`include "rtms_defs.vh"
module rtms_sequencer #(
	// Unsigned 32 bit counts: the 50 s on phase does not fit a signed integer
	parameter [31:0]  SHORT_PERIOD_CYC = `RTMS_CLK_HZ * `RTMS_SHORT_PERIOD_S,
	parameter [31:0]  LONG_ON_CYC      = `RTMS_CLK_HZ * `RTMS_LONG_ON_S,
	parameter [31:0]  LONG_OFF_CYC     = `RTMS_CLK_HZ * `RTMS_LONG_OFF_S,
	parameter integer FIFO_DEPTH       = `RTMS_FIFO_DEPTH
) (
	// Clock, reset, enable
	input  wire       i_clk,
	input  wire       i_rst_b,
	input  wire       i_ce,
	// Settings
	input  wire       i_test_enable,
	input  wire       i_long_pattern,
	// Byte stream toward the radio transmitter
	output wire       o_tx_valid,
	output wire [7:0] o_tx_data,
	input  wire       i_tx_ready,
	// Status
	output reg        o_active,
	output reg        o_long_silent,
	output reg  [7:0] o_seq_bcd
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE  = 2'b00;
	localparam [1:0] ST_SEND  = 2'b01;
	localparam [1:0] ST_WAIT  = 2'b10;
	localparam [1:0] ST_QUIET = 2'b11;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [5:0]  idx;
	reg  [5:0]  msg_len;
	reg  [31:0] pace_cnt;
	reg  [31:0] phase_cnt;
	reg  [3:0]  seq_hi;
	reg  [3:0]  seq_lo;
	reg  [7:0]  char;
	wire        fifo_ready;
	wire        push;
	wire        last_char;
	wire        phase_end;
	wire        pace_end;

	// Body text byte at a given position, lowercase letters cycled
	function [7:0] rtms_body_char;
		input [5:0] pos;
		begin
			rtms_body_char = `RTMS_CHR_BODY_BASE + {3'h0, pos[4:0] % `RTMS_BODY_LETTERS};
		end
	endfunction

	// Decimal digit increment with carry
	function [4:0] rtms_digit_inc;
		input [3:0] d;
		begin
			if (d == `RTMS_DIGIT_MAX) begin
				rtms_digit_inc = 5'h10;
			end else begin
				rtms_digit_inc = {1'b0, d + 4'h1};
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Message character generation
	// ----------------------------------------------------------------
	// Layout: tens, units, space, body, CR, LF
	always @* begin
		msg_len = (i_long_pattern ? `RTMS_LONG_BODY_LEN : `RTMS_SHORT_BODY_LEN) + `RTMS_FRAME_EXTRA;
		if (idx == `RTMS_POS_TENS) begin
			char = `RTMS_CHR_ZERO + {4'h0, seq_hi};
		end else if (idx == `RTMS_POS_UNITS) begin
			char = `RTMS_CHR_ZERO + {4'h0, seq_lo};
		end else if (idx == `RTMS_POS_SPACE) begin
			char = `RTMS_CHR_SPACE;
		end else if (idx == msg_len - `RTMS_TAIL_CR) begin
			char = `RTMS_CHR_CR;
		end else if (idx == msg_len - `RTMS_TAIL_LF) begin
			char = `RTMS_CHR_LF;
		end else begin
			char = rtms_body_char(idx - `RTMS_POS_BODY);
		end
	end

	assign push      = (state == ST_SEND) & fifo_ready;
	assign last_char = (idx == msg_len - `RTMS_TAIL_LF);
	assign pace_end  = (pace_cnt >= SHORT_PERIOD_CYC - 1);
	assign phase_end = (phase_cnt >= (o_long_silent ? LONG_OFF_CYC : LONG_ON_CYC) - 1);

	// ----------------------------------------------------------------
	// Sequencing state machine
	// ----------------------------------------------------------------
	// Next state
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (i_test_enable) begin
					next_state = ST_SEND;
				end
			end
			ST_SEND: begin
				if (push & last_char) begin
					if (!i_long_pattern) begin
						next_state = ST_WAIT;
					end else if (phase_end) begin
						next_state = ST_QUIET;
					end else begin
						// Back to back lines keep the carrier up for level readings
						next_state = ST_SEND;
					end
				end
			end
			ST_WAIT: begin
				if (pace_end) begin
					next_state = ST_SEND;
				end
			end
			ST_QUIET: begin
				if (phase_end) begin
					next_state = ST_SEND;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!i_test_enable) begin
			next_state = ST_IDLE;
		end
	end

	// State, index, counters and sequence number
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state         <= ST_IDLE;
			idx           <= 6'h00;
			pace_cnt      <= 32'h0;
			phase_cnt     <= 32'h0;
			seq_hi        <= 4'h0;
			seq_lo        <= 4'h0;
			o_active      <= 1'b0;
			o_long_silent <= 1'b0;
			o_seq_bcd     <= 8'h00;
		end else if (i_ce) begin
			state     <= next_state;
			o_active  <= (next_state != ST_IDLE);
			o_seq_bcd <= {seq_hi, seq_lo};
			// Message pacing counts from each message start in the short pattern; in the long pattern it runs on without restarting
			if (state == ST_IDLE || (state == ST_WAIT && pace_end)) begin
				pace_cnt <= 32'h0;
			end else begin
				pace_cnt <= pace_cnt + 32'h1;
			end
			// On and off phase timing of the long pattern
			if (state == ST_IDLE || !i_long_pattern) begin
				phase_cnt     <= 32'h0;
				o_long_silent <= 1'b0;
			end else if (phase_end && (state == ST_QUIET || (push & last_char))) begin
				phase_cnt     <= 32'h0;
				o_long_silent <= (state != ST_QUIET);
			end else if (!phase_end) begin
				phase_cnt <= phase_cnt + 32'h1;
			end
			// Character index and two digit counter
			if (state == ST_IDLE) begin
				idx    <= 6'h00;
				seq_hi <= 4'h0;
				seq_lo <= 4'h0;
			end else if (push) begin
				if (last_char) begin
					idx <= 6'h00;
					if (seq_lo == `RTMS_DIGIT_MAX) begin
						seq_lo <= 4'h0;
						seq_hi <= rtms_digit_inc(seq_hi) == 5'h10 ? 4'h0 : seq_hi + 4'h1;
					end else begin
						seq_lo <= seq_lo + 4'h1;
					end
				end else begin
					idx <= idx + 6'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Output buffer toward the transmitter
	// ----------------------------------------------------------------
	rtms_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_ce        (i_ce),
		.i_in_valid  (state == ST_SEND),
		.i_in_data   (char),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_tx_valid),
		.o_out_data  (o_tx_data), // Plain data path, no marker byte
		.i_out_ready (i_tx_ready)
	);
endmodule // rtms_sequencer
